// ---- rtl/ssr_pkg.sv ----
// Package for the synchronous serial port block: field positions, reset values
// and counts. Assumes a single 100 MHz system clock.
package ssr_pkg;
	// ==========================================================
	// Control register 1 fields
	localparam int CTL1_EN_BIT = 5;      // Port enable
	localparam int CTL1_CKP_BIT = 4;     // Clock idle polarity
	localparam int CTL1_MODE_MSB = 3;    // Mode field top bit
	localparam logic [7:0] CTL1_RESET = 8'h00;
	// Mode codes in control 1 bits 3:0
	localparam logic [3:0] MODE_MST_DIV4 = 4'h0;
	localparam logic [3:0] MODE_MST_DIV16 = 4'h1;
	localparam logic [3:0] MODE_MST_DIV64 = 4'h2;
	localparam logic [3:0] MODE_MST_BRG = 4'hA;
	localparam logic [3:0] MODE_SLV_SS = 4'h4;
	localparam logic [3:0] MODE_SLV_NOSS = 4'h5;
	// ==========================================================
	// Status register fields
	localparam int STAT_SMP_BIT = 7;     // Set: no sample event, shift takes last latched bit
	localparam int STAT_CKE_BIT = 6;     // Output on idle-to-active edge
	localparam int STAT_START_BIT = 3;   // Start detected
	localparam int STAT_BF_BIT = 0;      // Buffer full
	localparam logic [7:0] STAT_RESET = 8'h00;
	localparam logic [7:0] STAT_RW_MASK = 8'hC0;
	// ==========================================================
	// Counts
	localparam int BYTE_BITS = 8;
	localparam logic [7:0] BAUD_RESET = 8'h00;
	// Repeated start sequencer states
	typedef enum logic [2:0] {
		RS_IDLE, RS_SCL_LOW, RS_SDA_HIGH, RS_SCL_RISE, RS_BOTH_HIGH, RS_SDA_LOW
	} ssr_rs_e;
endpackage

// ---- rtl/ssr_baud_gen.sv ----
// Baud rate generator: reload counter with a one-cycle timeout pulse.
// Assumes reload comes from the address/baud register.
`timescale 1ns/10ps
module ssr_baud_gen
	import ssr_pkg::*;
#(
	parameter int W = 8
) (
	// Clock and reset
	input wire logic clk_i,
	input wire logic nrst_i,
	// Control
	input wire logic load_i,
	input wire logic run_i,
	input wire logic [W-1:0] reload_i,
	// Timeout
	output logic tick_o
);
	// ==========================================================
	// Counter
	logic [W-1:0] cnt_reg, cnt_next;

	// Count down; period is reload plus one cycles
	always_comb begin
		cnt_next = cnt_reg;
		tick_o = 1'b0;
		if (load_i) begin
			cnt_next = reload_i;
		end else if (run_i) begin
			if (cnt_reg == '0) begin
				tick_o = 1'b1;
				cnt_next = reload_i;
			end else begin
				cnt_next = cnt_reg - W'(1);
			end
		end
	end

	// Register
	always_ff @(posedge clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			cnt_reg <= '0;
		end else begin
			cnt_reg <= cnt_next;
		end
	end
endmodule

// ---- rtl/ssr_shifter.sv ----
// SPI bit engine: one byte shifted MSB first on given clock edges.
// Assumes edges are single-cycle pulses already synchronous to clk_i.
`timescale 1ns/10ps
module ssr_shifter
	import ssr_pkg::*;
(
	// Clock and reset
	input wire logic clk_i,
	input wire logic nrst_i,
	// Control
	input wire logic enable_i,
	input wire logic load_i,
	input wire logic [7:0] load_data_i,
	input wire logic sample_i,
	input wire logic shift_i,
	input wire logic sdi_i,
	// Results
	output logic sdo_o,
	output logic done_o,
	output logic [7:0] rx_data_o,
	output logic busy_o
);
	// ==========================================================
	// Shift state
	logic [7:0] sr_reg, sr_next;
	logic [3:0] cnt_reg, cnt_next;
	logic in_reg, in_next;

	// Sample latches the input bit, shift moves it in and pushes out next
	always_comb begin
		sr_next = sr_reg;
		cnt_next = cnt_reg;
		in_next = in_reg;
		done_o = 1'b0;
		if (!enable_i) begin
			cnt_next = 4'h0;
		end else if (load_i) begin
			sr_next = load_data_i;
			cnt_next = 4'h0;
		end else begin
			if (sample_i) begin
				in_next = sdi_i;
			end
			if (shift_i) begin
				sr_next = {sr_reg[6:0], sample_i ? sdi_i : in_reg};
				if (cnt_reg == 4'(BYTE_BITS - 1)) begin
					cnt_next = 4'h0;
					done_o = 1'b1;
				end else begin
					cnt_next = cnt_reg + 4'h1;
				end
			end
		end
	end

	assign sdo_o = sr_reg[7];
	assign rx_data_o = sr_next;
	assign busy_o = (cnt_reg != 4'h0);

	// Register
	always_ff @(posedge clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			sr_reg <= 8'h00;
			cnt_reg <= 4'h0;
			in_reg <= 1'b0;
		end else begin
			sr_reg <= sr_next;
			cnt_reg <= cnt_next;
			in_reg <= in_next;
		end
	end
endmodule

// ---- rtl/ssr_serial_port.sv ----
// Synchronous serial port: SPI master/slave plus I2C repeated start.
// Assumes all pin inputs are synchronous to CLK_SYS_I; software reaches
// the registers through plain write strobes and read ports.
//
// Functional notes
// - Control 1 fully readable and writable
// - Status bits 5:0 read-only, 7:6 writable
// - Baud register reloads the master rate generator
// - Shift register reachable only via buffer
// - Full byte copies to buffer, sets flag
// - Buffer write outside restart loads buffer, and shifter too if enabled
// - Control bits select mode, polarity, rate; status bit 6 selects phase
// - Master drives clock pin; slave takes it
// - Enable bit hands pins to serial port
// - Repeated start only accepted while idle
// - Pull SCL low, then SDA high one period
// - Release SCL, both high one period
// - SDA low one period, SCL low, finish
// - Start bit immediate; flag after timeout
// - Collision on SDA low or early SCL fall
`timescale 1ns/10ps
module ssr_serial_port
	import ssr_pkg::*;
(
	// Clock and reset
	input wire logic CLK_SYS_I,
	input wire logic NRST_I,
	// Register writes
	input wire logic CTL1_WR_I,
	input wire logic STAT_WR_I,
	input wire logic BUF_WR_I,
	input wire logic BAUD_WR_I,
	input wire logic [7:0] WDATA_I,
	input wire logic BUF_RD_I,
	// Flag clears and repeated start request
	input wire logic IRQ_FLAG_CLR_I,
	input wire logic COLL_CLR_I,
	input wire logic RSTART_REQ_I,
	// Register reads
	output logic [7:0] CTL1_O,
	output logic [7:0] STAT_O,
	output logic [7:0] BUF_O,
	output logic [7:0] BAUD_O,
	output logic IRQ_FLAG_O,
	output logic COLL_O,
	output logic RSTART_BUSY_O,
	output logic PORT_ACTIVE_O,
	// SPI pins
	input wire logic SCK_I,
	output logic SCK_O,
	output logic SCK_OE_O,
	input wire logic SDI_I,
	output logic SDO_O,
	output logic SDO_OE_O,
	input wire logic SS_N_I,
	// I2C pins, open drain
	input wire logic SCL_I,
	output logic SCL_O,
	output logic SCL_OE_O,
	input wire logic SDA_I,
	output logic SDA_O,
	output logic SDA_OE_O
);
	// ==========================================================
	// Register state
	logic [7:0] ctl1_reg, ctl1_next;
	logic [1:0] stat_hi_reg, stat_hi_next;
	logic [7:0] buf_reg, buf_next;
	logic [7:0] baud_reg, baud_next;
	logic bf_reg, bf_next;
	logic irq_reg, irq_next;
	logic start_reg, start_next;
	logic coll_reg, coll_next;

	// Decoded configuration
	logic en, ckp, smp, cke, master, use_ss;
	logic [3:0] mode;

	assign en = ctl1_reg[CTL1_EN_BIT];
	assign ckp = ctl1_reg[CTL1_CKP_BIT];
	assign mode = ctl1_reg[CTL1_MODE_MSB:0];
	assign smp = stat_hi_reg[1];
	assign cke = stat_hi_reg[0];

	// Master when mode is one of the clock-rate codes
	function automatic logic is_master(input logic [3:0] m);
		is_master = (m == MODE_MST_DIV4) || (m == MODE_MST_DIV16) ||
			(m == MODE_MST_DIV64) || (m == MODE_MST_BRG);
	endfunction

	assign master = is_master(mode);
	assign use_ss = (mode == MODE_SLV_SS);

	// ==========================================================
	// Master clock pacing
	logic brg_tick, brg_load, brg_run;
	logic [5:0] pre_reg, pre_next;
	logic half_tick;
	logic sck_int_reg, sck_int_next;
	logic rs_active;

	// Fixed dividers reuse a free prescaler; BRG mode uses the generator
	always_comb begin
		pre_next = pre_reg + 6'h01;
		half_tick = 1'b0;
		case (mode)
			MODE_MST_DIV4: half_tick = pre_reg[0];
			MODE_MST_DIV16: half_tick = &pre_reg[2:0];
			MODE_MST_DIV64: half_tick = &pre_reg[4:0];
			MODE_MST_BRG: half_tick = brg_tick;
			default: half_tick = 1'b0;
		endcase
	end

	// ==========================================================
	// SPI engine wiring
	logic sh_busy, sh_done, sh_sdo, lead_edge, trail_edge;
	logic sck_in_prev_reg, sck_in_prev_next;
	logic sck_active_level, sck_rise, sck_fall;
	logic slave_sel, sample_ev, shift_ev, spi_load;
	logic [7:0] rx_byte;
	logic master_run;

	logic sh_busy_or_load;
	logic load_pend_reg, load_pend_next;
	// Master toggles only while a byte is in flight or waiting to start
	assign sh_busy_or_load = sh_busy || load_pend_reg;
	assign master_run = en && master && sh_busy_or_load;

	// Edge view of the clock in both roles, relative to idle polarity
	assign sck_active_level = master ? sck_int_reg : SCK_I;
	assign sck_rise = sck_active_level && !sck_in_prev_reg;
	assign sck_fall = !sck_active_level && sck_in_prev_reg;
	// Leading edge leaves idle; trailing edge returns to idle
	assign lead_edge = ckp ? sck_fall : sck_rise;
	assign trail_edge = ckp ? sck_rise : sck_fall;
	assign slave_sel = !use_ss || !SS_N_I;

	// Sample on leading edge (cke=1 samples on trailing), shift on the other;
	// with smp set no sample event fires, so the shift edge takes the last latched bit
	assign sample_ev = en && slave_sel && (smp ? 1'b0 : (cke ? trail_edge : lead_edge));
	assign shift_ev = en && slave_sel && (cke ? lead_edge : trail_edge);

	// buffer write outside a restart loads the shifter at once, if the port is enabled
	assign spi_load = BUF_WR_I && !rs_active;

	ssr_shifter u_shifter (
		.clk_i(CLK_SYS_I),
		.nrst_i(NRST_I),
		.enable_i(en),
		.load_i(spi_load),
		.load_data_i(WDATA_I),
		.sample_i(sample_ev),
		.shift_i(shift_ev),
		.sdi_i(SDI_I),
		.sdo_o(sh_sdo),
		.done_o(sh_done),
		.rx_data_o(rx_byte),
		.busy_o(sh_busy)
	);

	// Master clock toggle and pending-load tracking
	always_comb begin
		sck_int_next = sck_int_reg;
		load_pend_next = load_pend_reg;
		sck_in_prev_next = sck_active_level;
		if (spi_load && master) begin
			load_pend_next = 1'b1;
		end else if (sh_busy) begin
			load_pend_next = 1'b0;
		end
		if (!en || !master) begin
			sck_int_next = ckp;
			load_pend_next = 1'b0;
		end else if (master_run && half_tick) begin
			sck_int_next = !sck_int_reg;
		end
	end

	// ==========================================================
	// Repeated start sequencer
	ssr_rs_e rs_reg, rs_next;
	logic scl_low_drive, sda_low_drive;
	logic scl_prev_reg;
	logic rs_coll, rs_done;

	assign rs_active = (rs_reg != RS_IDLE);

	always_comb begin
		rs_next = rs_reg;
		brg_load = 1'b0;
		scl_low_drive = 1'b0;
		sda_low_drive = 1'b0;
		rs_coll = 1'b0;
		rs_done = 1'b0;
		case (rs_reg)
			RS_IDLE: begin
				// ignored unless idle and no SPI byte in flight
				if (RSTART_REQ_I && en && !sh_busy_or_load) begin
					rs_next = RS_SCL_LOW;
				end
			end
			RS_SCL_LOW: begin
				// pull SCL low, wait to see it low
				scl_low_drive = 1'b1;
				if (!SCL_I) begin
					brg_load = 1'b1;
					rs_next = RS_SDA_HIGH;
				end
			end
			RS_SDA_HIGH: begin
				scl_low_drive = 1'b1;
				if (brg_tick) begin
					// SDA must be high at timeout
					if (SDA_I) begin
						rs_next = RS_SCL_RISE;
					end else begin
						rs_coll = 1'b1;
					end
				end
			end
			RS_SCL_RISE: begin
				// Rise taken against the previous sample, so a stretched clock waits
				if (SCL_I && !scl_prev_reg) begin
					if (!SDA_I) begin
						rs_coll = 1'b1;
					end else begin
						brg_load = 1'b1;
						rs_next = RS_BOTH_HIGH;
					end
				end
			end
			RS_BOTH_HIGH: begin
				// early SCL fall or SDA low
				if (!SCL_I || !SDA_I) begin
					rs_coll = 1'b1;
				end else if (brg_tick) begin
					rs_next = RS_SDA_LOW;
				end
			end
			RS_SDA_LOW: begin
				// SDA low one period, then SCL low, no reload
				sda_low_drive = 1'b1;
				if (brg_tick) begin
					rs_done = 1'b1;
					rs_next = RS_IDLE;
				end
			end
			default: rs_next = RS_IDLE;
		endcase
		// collision aborts and releases both lines
		if (rs_coll || !en) begin
			rs_next = RS_IDLE;
		end
	end

	// Generator runs during the sequence or for BRG master clocking
	assign brg_run = rs_active || (en && mode == MODE_MST_BRG && master_run);

	ssr_baud_gen #(
		.W(8)
	) u_baud (
		.clk_i(CLK_SYS_I),
		.nrst_i(NRST_I),
		.load_i(brg_load),
		.run_i(brg_run),
		.reload_i(baud_reg),
		.tick_o(brg_tick)
	);

	// SDA held low after completion until software drives the next event
	logic sda_hold_reg, sda_hold_next;
	assign sda_hold_next = rs_done ? 1'b1 : ((!en || rs_next != RS_IDLE) ? 1'b0 : sda_hold_reg);

	// ==========================================================
	// Register file next values
	always_comb begin
		ctl1_next = ctl1_reg;
		stat_hi_next = stat_hi_reg;
		buf_next = buf_reg;
		baud_next = baud_reg;
		bf_next = bf_reg;
		irq_next = irq_reg;
		start_next = start_reg;
		coll_next = coll_reg;
		// control 1 fully writable; reconfigure by rewrite
		if (CTL1_WR_I) begin
			ctl1_next = WDATA_I;
		end
		// only upper two status bits writable
		if (STAT_WR_I) begin
			stat_hi_next = WDATA_I[STAT_SMP_BIT:STAT_CKE_BIT];
		end
		if (BAUD_WR_I) begin
			baud_next = WDATA_I;
		end
		if (BUF_RD_I) begin
			bf_next = 1'b0;
		end
		// Clears first so simultaneous hardware events win
		if (IRQ_FLAG_CLR_I) begin
			irq_next = 1'b0;
		end
		if (COLL_CLR_I) begin
			coll_next = 1'b0;
		end
		// software buffer writes go only through this path
		if (spi_load) begin
			buf_next = WDATA_I;
		end
		// completed byte moves to buffer with flag
		if (sh_done) begin
			buf_next = rx_byte;
			bf_next = 1'b1;
			irq_next = 1'b1;
		end
		// start bit on the SDA fall; flag on timeout
		if (rs_reg == RS_SDA_LOW && !SDA_I && SCL_I) begin
			start_next = 1'b1;
		end
		if (rs_done) begin
			irq_next = 1'b1;
		end
		if (rs_next == RS_SCL_LOW && rs_reg == RS_IDLE) begin
			start_next = 1'b0;
		end
		if (rs_coll) begin
			coll_next = 1'b1;
		end
	end

	// Registers
	always_ff @(posedge CLK_SYS_I or negedge NRST_I) begin
		if (!NRST_I) begin
			ctl1_reg <= CTL1_RESET;
			stat_hi_reg <= 2'b00;
			buf_reg <= 8'h00;
			baud_reg <= BAUD_RESET;
			bf_reg <= 1'b0;
			irq_reg <= 1'b0;
			start_reg <= 1'b0;
			coll_reg <= 1'b0;
			pre_reg <= 6'h00;
			sck_int_reg <= 1'b0;
			sck_in_prev_reg <= 1'b0;
			load_pend_reg <= 1'b0;
			rs_reg <= RS_IDLE;
			scl_prev_reg <= 1'b1;
			sda_hold_reg <= 1'b0;
		end else begin
			ctl1_reg <= ctl1_next;
			stat_hi_reg <= stat_hi_next;
			buf_reg <= buf_next;
			baud_reg <= baud_next;
			bf_reg <= bf_next;
			irq_reg <= irq_next;
			start_reg <= start_next;
			coll_reg <= coll_next;
			pre_reg <= pre_next;
			sck_int_reg <= sck_int_next;
			sck_in_prev_reg <= sck_in_prev_next;
			load_pend_reg <= load_pend_next;
			rs_reg <= rs_next;
			scl_prev_reg <= SCL_I;
			sda_hold_reg <= sda_hold_next;
		end
	end

	// ==========================================================
	// Outputs
	assign CTL1_O = ctl1_reg;
	assign STAT_O = {stat_hi_reg, 2'b00, start_reg, 2'b00, bf_reg};
	assign BUF_O = buf_reg;
	assign BAUD_O = baud_reg;
	assign IRQ_FLAG_O = irq_reg;
	assign COLL_O = coll_reg;
	assign RSTART_BUSY_O = rs_active;
	// pins belong to the port only while enabled
	assign PORT_ACTIVE_O = en;
	// master drives the clock, slave leaves it an input
	assign SCK_O = sck_int_reg;
	assign SCK_OE_O = en && master;
	assign SDO_O = sh_sdo;
	// Slave with select releases data out while deselected
	assign SDO_OE_O = en && slave_sel;
	// Open drain: only ever drive low
	assign SCL_O = 1'b0;
	assign SCL_OE_O = scl_low_drive || (rs_done) || (sda_hold_reg && !rs_active);
	assign SDA_O = 1'b0;
	assign SDA_OE_O = sda_low_drive || (sda_hold_reg && !rs_active);
endmodule

// ---- testbench/ssr_serial_port_asserts.sv ----
// Checker for the serial port: register, pin direction and restart relations.
// Assumes it is bound to the top module and sees only its ports.
`timescale 1ns/10ps
module ssr_serial_port_asserts
	import ssr_pkg::*;
(
	// Clock and reset
	input wire logic CLK_SYS_I,
	input wire logic NRST_I,
	// Software side
	input wire logic CTL1_WR_I,
	input wire logic STAT_WR_I,
	input wire logic BUF_WR_I,
	input wire logic BAUD_WR_I,
	input wire logic [7:0] WDATA_I,
	input wire logic RSTART_REQ_I,
	input wire logic [7:0] CTL1_O,
	input wire logic [7:0] STAT_O,
	input wire logic [7:0] BUF_O,
	input wire logic [7:0] BAUD_O,
	input wire logic IRQ_FLAG_O,
	input wire logic COLL_O,
	input wire logic RSTART_BUSY_O,
	input wire logic PORT_ACTIVE_O,
	// Pin enables
	input wire logic SCK_OE_O,
	input wire logic SCL_OE_O,
	input wire logic SDA_OE_O
);
	// ==========================================================
	// Helpers
	// Master modes own the clock pin only while the port is on
	wire logic master_w = CTL1_O[CTL1_EN_BIT] && (CTL1_O[3:0] == MODE_MST_DIV4 ||
		CTL1_O[3:0] == MODE_MST_DIV16 || CTL1_O[3:0] == MODE_MST_DIV64 ||
		CTL1_O[3:0] == MODE_MST_BRG);
	default clocking @(posedge CLK_SYS_I); endclocking
	default disable iff (!NRST_I);
	// ==========================================================
	// Properties
	ctl1_write_a: assert property (CTL1_WR_I |=> CTL1_O == $past(WDATA_I))
		else $error("control 1 did not take the write");
	stat_mask_a: assert property (STAT_WR_I |=> STAT_O[7:6] == $past(WDATA_I[7:6]))
		else $error("status upper bits did not take the write");
	baud_write_a: assert property (BAUD_WR_I |=> BAUD_O == $past(WDATA_I))
		else $error("baud reload did not take the write");
	buf_load_a: assert property (BUF_WR_I && !RSTART_BUSY_O |=> BUF_O == $past(WDATA_I))
		else $error("buffer write lost");
	sck_dir_a: assert property (SCK_OE_O == master_w)
		else $error("clock pin direction wrong for mode");
	port_enable_a: assert property (PORT_ACTIVE_O == CTL1_O[CTL1_EN_BIT])
		else $error("port active differs from enable bit");
	rs_accept_a: assert property ($rose(RSTART_BUSY_O) |-> $past(RSTART_REQ_I))
		else $error("restart began without a request");
	rs_scl_low_a: assert property ($rose(RSTART_BUSY_O) |-> ##[0:1] SCL_OE_O)
		else $error("restart did not pull the clock line");
	rs_finish_a: assert property ($fell(RSTART_BUSY_O) && !COLL_O && PORT_ACTIVE_O |->
		##[0:1] (IRQ_FLAG_O && SDA_OE_O && SCL_OE_O))
		else $error("restart end left lines or flag wrong");
	coll_release_a: assert property ($rose(COLL_O) |-> ##[0:1] (!SCL_OE_O && !SDA_OE_O))
		else $error("collision did not release the lines");
endmodule
bind ssr_serial_port ssr_serial_port_asserts u_ssr_serial_port_asserts (.CLK_SYS_I(CLK_SYS_I),
	.NRST_I(NRST_I), .CTL1_WR_I(CTL1_WR_I), .STAT_WR_I(STAT_WR_I), .BUF_WR_I(BUF_WR_I),
	.BAUD_WR_I(BAUD_WR_I), .WDATA_I(WDATA_I), .RSTART_REQ_I(RSTART_REQ_I), .CTL1_O(CTL1_O),
	.STAT_O(STAT_O), .BUF_O(BUF_O), .BAUD_O(BAUD_O), .IRQ_FLAG_O(IRQ_FLAG_O), .COLL_O(COLL_O),
	.RSTART_BUSY_O(RSTART_BUSY_O), .PORT_ACTIVE_O(PORT_ACTIVE_O), .SCK_OE_O(SCK_OE_O),
	.SCL_OE_O(SCL_OE_O), .SDA_OE_O(SDA_OE_O));

// ---- testbench/ssr_bus_model.sv ----
// Far side model: one SPI slave byte shifter and an I2C bus with pull-ups.
// Assumes SPI clock idle low, data sampled on rising and changed on falling.
`timescale 1ns/10ps
module ssr_bus_model (
	// Clock
	input wire logic clk_i,
	// SPI side
	input wire logic sck_i,
	input wire logic sdo_i,
	input wire logic load_i,
	input wire logic [7:0] tx_i,
	output logic sdi_o,
	output logic [7:0] rx_o,
	// I2C side
	input wire logic scl_oe_i,
	input wire logic sda_oe_i,
	input wire logic sda_hold_i,
	output logic scl_o,
	output logic sda_o
);
	logic sck_q;
	logic [7:0] tx_q;
	// slave pin directions
	// Shift out on falling, fill with inverted bits so stale data never matches
	always_ff @(posedge clk_i) begin
		sck_q <= sck_i;
		if (load_i) begin
			tx_q <= tx_i;
		end else if (sck_q && !sck_i) begin
			tx_q <= {tx_q[6:0], !tx_q[0]};
		end
		if (!sck_q && sck_i) begin
			rx_o <= {rx_o[6:0], sdo_i};
		end
	end
	assign sdi_o = tx_q[7];
	// Open drain wires: any enable pulls low, otherwise the pull-up wins
	assign scl_o = !scl_oe_i;
	assign sda_o = !(sda_oe_i || sda_hold_i);
endmodule

// ---- testbench/tb.sv ----
// Testbench for the serial port: register access, SPI byte and I2C restart.
// Assumes the bus model stands on the pins; strobes change on falling edges.
`timescale 1ns/10ps
`define CHK(a, b) begin checked++; if ((a) !== (b)) begin errors++; $display("wrong value at %0t: %h vs %h", $time, (a), (b)); end end
module tb;
	import ssr_pkg::*;
	logic clk, nrst, ss_n, sda_hold, load;
	logic [7:0] st, wd, tx, ctl1, stat, buf_q, baud, rx;
	logic irq, coll, busy, act, sck, sck_oe, sdo, sdo_oe, sdi, scl, sda, scl_oe, sda_oe;
	int errors, checked, n;
	logic [3:0] modes [6] = '{MODE_MST_DIV4, MODE_MST_DIV16, MODE_MST_DIV64, MODE_MST_BRG,
		MODE_SLV_SS, MODE_SLV_NOSS};
	// ==========================================================
	// Design and far side; strobe bit k selects one write, read, clear or restart request port
	ssr_serial_port u_ssr_serial_port (.CLK_SYS_I(clk), .NRST_I(nrst), .CTL1_WR_I(st[0]),
		.STAT_WR_I(st[1]), .BUF_WR_I(st[2]), .BAUD_WR_I(st[3]), .WDATA_I(wd), .BUF_RD_I(st[4]),
		.IRQ_FLAG_CLR_I(st[5]), .COLL_CLR_I(st[6]), .RSTART_REQ_I(st[7]), .CTL1_O(ctl1),
		.STAT_O(stat), .BUF_O(buf_q), .BAUD_O(baud), .IRQ_FLAG_O(irq), .COLL_O(coll),
		.RSTART_BUSY_O(busy), .PORT_ACTIVE_O(act), .SCK_I(sck_oe ? sck : 1'b0), .SCK_O(sck),
		.SCK_OE_O(sck_oe), .SDI_I(sdi), .SDO_O(sdo), .SDO_OE_O(sdo_oe), .SS_N_I(ss_n),
		.SCL_I(scl), .SCL_O(), .SCL_OE_O(scl_oe), .SDA_I(sda), .SDA_O(), .SDA_OE_O(sda_oe));
	ssr_bus_model u_ssr_bus_model (.clk_i(clk), .sck_i(sck_oe && sck), .sdo_i(sdo),
		.load_i(load), .tx_i(tx), .sdi_o(sdi), .rx_o(rx), .scl_oe_i(scl_oe),
		.sda_oe_i(sda_oe), .sda_hold_i(sda_hold), .scl_o(scl), .sda_o(sda));
	// ==========================================================
	// Tasks
	// One strobe cycle; a gap cycle keeps back-to-back calls apart
	task pulse(input int k, input logic [7:0] d);
		@(negedge clk);
		st[k] = 1'b1;
		wd = d;
		@(negedge clk);
		st = 8'h00;
	endtask
	// Reconfigure as master, preload the far side, then write the buffer
	task xfer(input logic [3:0] m, input logic [7:0] t, input logic [7:0] w);
		pulse(0, 8'h00);
		pulse(0, {4'h2, m});
		@(negedge clk);
		tx = t;
		load = 1'b1;
		@(negedge clk);
		load = 1'b0;
		pulse(2, w);
	endtask
	// Bounded wait for the flag (w=0) or for the sequencer to go idle (w=1)
	task await(input int w, input int lim);
		for (n = 0; n < lim; n++) begin
			if (w ? !busy : irq) break;
			@(negedge clk);
		end
		if (n == lim) begin
			errors++;
			end_of_test();
		end
	endtask
	task end_of_test();
		if (errors == 0 && checked > 0) $display("TEST PASSED");
		else $display("TEST FAILED");
		$finish;
	endtask
	// ==========================================================
	// Clock
	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end
	// ==========================================================
	// Main sequence
	initial begin
		{nrst, ss_n, sda_hold, load} = 4'b0100;
		st = 8'h00;
		wd = 8'h00;
		tx = 8'h00;
		errors = 0;
		checked = 0;
		repeat (10) @(negedge clk);
		nrst = 1'b1;
		@(negedge clk);
		`CHK({ctl1, stat, buf_q, baud}, {CTL1_RESET, STAT_RESET, 8'h00, BAUD_RESET})
		pulse(0, 8'h1F);
		`CHK(ctl1, 8'h1F)
		pulse(1, 8'hFF);
		`CHK(stat, STAT_RW_MASK)
		pulse(3, 8'h03);
		`CHK(baud, 8'h03)
		foreach (modes[i]) begin
			pulse(0, 8'h00);
			`CHK({act, sck_oe, sdo_oe}, 3'b000)
			pulse(0, {4'h2, modes[i]});
			`CHK({act, sck_oe, sdo_oe}, {1'b1, i < 4, i != 4})
		end
		// SPI byte exchange in the fastest master mode
		pulse(0, 8'h00);
		pulse(1, 8'h00);
		xfer(MODE_MST_DIV4, 8'h5A, 8'hC3);
		`CHK(buf_q, 8'hC3)
		pulse(7, 8'h00);
		`CHK(busy, 1'b0)
		await(0, 200);
		`CHK({buf_q, stat[STAT_BF_BIT], rx}, {8'h5A, 1'b1, 8'hC3})
		pulse(4, 8'h00);
		pulse(5, 8'h00);
		`CHK({stat[STAT_BF_BIT], irq}, 2'b00)
		// Same exchange paced by the generator: reload 3 gives eight cycles a bit
		xfer(MODE_MST_BRG, 8'hA5, 8'h3C);
		await(0, 200);
		`CHK({buf_q, rx}, {8'hA5, 8'h3C})
		`CHK(n >= 60, 1'b1)
		pulse(4, 8'h00);
		pulse(5, 8'h00);
		// Restart refused while the port is off
		pulse(0, {4'h0, MODE_MST_BRG});
		pulse(7, 8'h00);
		`CHK(busy, 1'b0)
		pulse(0, {4'h2, MODE_MST_BRG});
		pulse(7, 8'h00);
		`CHK(busy, 1'b1)
		await(1, 300);
		`CHK({coll, irq, stat[STAT_START_BIT], scl_oe, sda_oe}, 5'b01111)
		// Three generator periods of four cycles at least
		`CHK(n >= 12, 1'b1)
		// Another party holds the data line low during the restart
		pulse(5, 8'h00);
		sda_hold = 1'b1;
		pulse(7, 8'h00);
		await(1, 300);
		`CHK({coll, scl_oe, sda_oe}, 3'b100)
		sda_hold = 1'b0;
		pulse(6, 8'h00);
		`CHK(coll, 1'b0)
		// Data line pulled low once both lines stand high
		pulse(7, 8'h00);
		repeat (6) @(negedge clk);
		sda_hold = 1'b1;
		await(1, 300);
		`CHK({coll, irq, scl_oe, sda_oe}, 4'b1000)
		sda_hold = 1'b0;
		end_of_test();
	end
endmodule
